// *** touch_gate_pkg.sv ***
// constants, register map and carriers for the touch repeat and multi-touch gate
//
// How it works
// RL1: one repeat enable per input, reset all ones
// RL2: repeat disabled: interrupt only on touch, release
// RL3: repeat enabled: held touch repeats at rate
// RL4: blocking enable is bit 7, set at reset
// RL5: blocking off: every touch reported, none suppressed by the limit
// RL6: blocking on: accept up to limit, latch until release
// RL7: free slots filled in scan order one to eight
// RL8: limit field bits 3:2 decode one to four
// RL9: exceeding limit blocks extras, sets simultaneous flag
// RL10: pattern enable bit 7, off at reset
// RL11: threshold select 12.5, 25, 37.5, 100 percent
// RL12: count mode: hits at least pattern popcount
// RL13: compare mode: every pattern input must hit
// RL14: event sets flag; alert only when enabled
// RL15: all touches blocked while pattern condition holds
// RL16: flag clears on host clear after condition gone
// RL17: pattern register one bit per input, all ones
// RL18: pattern evaluated on one polling cycle's results
// RL19: unassigned config bits read zero, ignore writes
package touch_gate_pkg;

	localparam int unsigned NUM_INPUTS = 8;
	localparam int unsigned THR_W = 7;
	localparam int unsigned DELTA_W = 8;

	// register offsets
	localparam logic [7:0] ADDR_REPEAT_RATE_ENABLE = 8'h28;
	localparam logic [7:0] ADDR_MULTI_TOUCH_CONFIG = 8'h2a;
	localparam logic [7:0] ADDR_TOUCH_PATTERN_CONFIG = 8'h2b;
	localparam logic [7:0] ADDR_TOUCH_PATTERN = 8'h2d;

	// reset values
	localparam logic [7:0] RST_REPEAT_RATE_ENABLE = 8'hff;
	localparam logic [7:0] RST_MULTI_TOUCH_CONFIG = 8'h80;
	localparam logic [7:0] RST_TOUCH_PATTERN_CONFIG = 8'h00;
	localparam logic [7:0] RST_TOUCH_PATTERN = 8'hff;

	// writable bits of the configuration registers
	localparam logic [7:0] MASK_MULTI_TOUCH_CONFIG = 8'h8c;
	localparam logic [7:0] MASK_TOUCH_PATTERN_CONFIG = 8'h8f;

	// field positions
	localparam int unsigned BIT_SIMUL_BLOCK_ENABLE = 7;
	localparam int unsigned BIT_LIMIT_LO = 2;
	localparam int unsigned BIT_PATTERN_DETECT_ENABLE = 7;
	localparam int unsigned BIT_THRESH_LO = 2;
	localparam int unsigned BIT_PATTERN_COMPARE_MODE = 1;
	localparam int unsigned BIT_PATTERN_ALERT_ENABLE = 0;

	// pattern threshold fraction codes
	typedef enum logic [1:0] {
		PTH_12P5 = 2'b00,
		PTH_25 = 2'b01,
		PTH_37P5 = 2'b10,
		PTH_100 = 2'b11
	} pattern_thresh_t;

	// results of one polling cycle
	typedef struct packed {
		logic [NUM_INPUTS-1:0] touch;
		logic [NUM_INPUTS-1:0] noise;
		logic [NUM_INPUTS-1:0][DELTA_W-1:0] delta;
	} poll_result_t;

	// threshold context of the current power state
	typedef struct packed {
		logic standby;
		logic [THR_W-1:0] standby_thresh;
		logic [NUM_INPUTS-1:0][THR_W-1:0] active_thresh;
	} thresh_ctx_t;

	// host register access
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

endpackage

// *** touch_repeat_gate.sv ***
// touch repeat enables, multiple-touch blocking and touch pattern detection
module touch_repeat_gate
	import touch_gate_pkg::*;
(
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// host register access
	input wire reg_req_t reg_req_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// polling cycle results
	input wire logic poll_done_in,
	input wire poll_result_t poll_in,
	input wire thresh_ctx_t thresh_in,
	// interrupt context from the surrounding device
	input wire logic repeat_tick_in,
	input wire logic release_irq_enable_in,
	input wire logic main_irq_clear_in,
	// gated results
	output logic [NUM_INPUTS-1:0] touch_status_out,
	output logic touch_irq_out,
	output logic simul_touch_flag_out,
	output logic pattern_event_flag_out,
	output logic pattern_block_out,
	output logic alert_n_out
);

	// register state
	logic [7:0] repeat_rate_enable_q;
	logic [7:0] multi_touch_config_q;
	logic [7:0] touch_pattern_config_q;
	logic [7:0] touch_pattern_q;
	logic [7:0] rdata_q;
	logic rvalid_q;

	// gating state
	logic [NUM_INPUTS-1:0] accepted_q;
	logic [NUM_INPUTS-1:0] accepted_d;
	logic simul_touch_flag_q;
	logic pattern_active_q;
	logic pattern_event_flag_q;
	logic touch_irq_q;

	// decoded configuration
	logic simul_block_enable;
	logic [1:0] simul_touch_limit;
	logic [2:0] limit_count;
	logic pattern_detect_enable;
	pattern_thresh_t pattern_threshold_select;
	logic pattern_compare_mode;
	logic pattern_alert_enable;

	// per-input pattern evaluation
	logic [NUM_INPUTS-1:0] above_pattern;
	logic [NUM_INPUTS-1:0] pattern_hit;
	logic [3:0] hit_count;
	logic [3:0] pattern_count;
	logic pattern_cond;

	// blocking evaluation
	logic over_limit;
	logic [NUM_INPUTS-1:0] new_touch;
	logic [NUM_INPUTS-1:0] released;
	logic irq_event;
	logic touch_event;
	logic release_event;
	logic repeat_event;

	// register write decode
	logic wr_repeat_rate_enable;
	logic wr_multi_touch_config;
	logic wr_touch_pattern_config;
	logic wr_touch_pattern;

	// field width and shift counts of the pattern threshold fractions
	localparam int unsigned FIELD_W = 2;
	localparam int unsigned SHIFT_EIGHTH = 3;
	localparam int unsigned SHIFT_QUARTER = 2;

	// count of set bits in an input vector
	function automatic logic [3:0] popcount(input logic [NUM_INPUTS-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	// multiple touch field decode
	always_comb begin
		simul_block_enable = multi_touch_config_q[BIT_SIMUL_BLOCK_ENABLE]; // RL4
		simul_touch_limit = multi_touch_config_q[BIT_LIMIT_LO +: FIELD_W];
		limit_count = {1'b0, simul_touch_limit} + 3'h1; // RL8
	end

	// pattern field decode
	always_comb begin
		pattern_detect_enable = touch_pattern_config_q[BIT_PATTERN_DETECT_ENABLE];
		pattern_threshold_select = pattern_thresh_t'(touch_pattern_config_q[BIT_THRESH_LO +: FIELD_W]);
		pattern_compare_mode = touch_pattern_config_q[BIT_PATTERN_COMPARE_MODE];
		pattern_alert_enable = touch_pattern_config_q[BIT_PATTERN_ALERT_ENABLE];
	end

	// per-input pattern threshold and comparison
	generate
		for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_input
			logic [THR_W-1:0] base_thr;
			logic [THR_W-1:0] pat_thr;
			// standby uses the common standby threshold
			assign base_thr = thresh_in.standby ? thresh_in.standby_thresh
				: thresh_in.active_thresh[g];
			// fraction of the base threshold
			always_comb begin
				unique case (pattern_threshold_select)
					PTH_12P5: pat_thr = base_thr >> SHIFT_EIGHTH; // RL11
					PTH_25: pat_thr = base_thr >> SHIFT_QUARTER; // RL11
					PTH_37P5: pat_thr = (base_thr >> SHIFT_QUARTER) + (base_thr >> SHIFT_EIGHTH); // RL11
					PTH_100: pat_thr = base_thr; // RL11
				endcase
			end
			assign above_pattern[g] = poll_in.delta[g] > {1'b0, pat_thr};
			assign pattern_hit[g] = above_pattern[g] | poll_in.noise[g];
		end
	endgenerate

	// pattern condition over this polling cycle's results
	always_comb begin
		hit_count = popcount(pattern_hit); // RL18
		pattern_count = popcount(touch_pattern_q); // RL17
		if (!pattern_detect_enable) begin
			pattern_cond = 1'b0; // RL10
		end else if (pattern_compare_mode) begin
			pattern_cond = (pattern_hit & touch_pattern_q) == touch_pattern_q; // RL13
		end else begin
			pattern_cond = hit_count >= pattern_count; // RL12
		end
	end

	// choose which detected touches are flagged this polling cycle
	always_comb begin
		logic [3:0] taken;
		taken = 4'h0;
		accepted_d = accepted_q;
		over_limit = 1'b0;
		if (poll_done_in) begin
			if (pattern_cond) begin
				accepted_d = '0; // RL15
			end else if (!simul_block_enable) begin
				accepted_d = poll_in.touch; // RL5
			end else begin
				// held inputs keep their slot until released
				accepted_d = accepted_q & poll_in.touch; // RL6
				taken = popcount(accepted_d);
				for (int i = 0; i < NUM_INPUTS; i++) begin
					if (poll_in.touch[i] && !accepted_d[i]) begin
						if (taken < {1'b0, limit_count}) begin
							accepted_d[i] = 1'b1; // RL7
							taken = taken + 4'h1;
						end else begin
							over_limit = 1'b1; // RL9
						end
					end
				end
			end
		end
	end

	// touch edges and interrupt events
	always_comb begin
		new_touch = accepted_d & ~accepted_q;
		released = accepted_q & ~accepted_d;
		touch_event = |new_touch; // RL2
		release_event = release_irq_enable_in & (|released); // RL2
		repeat_event = repeat_tick_in & (|(accepted_q & accepted_d & repeat_rate_enable_q)); // RL3
		irq_event = touch_event | release_event | repeat_event;
	end

	// accepted touch latch
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			accepted_q <= '0;
		end else begin
			accepted_q <= accepted_d; // RL6
		end
	end

	// interrupt event pulse to the main status logic
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			touch_irq_q <= 1'b0;
		end else begin
			touch_irq_q <= irq_event;
		end
	end

	// simultaneous-touch flag, a new event wins over the clear
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			simul_touch_flag_q <= 1'b0;
		end else if (over_limit) begin
			simul_touch_flag_q <= 1'b1; // RL9
		end else if (main_irq_clear_in) begin
			simul_touch_flag_q <= 1'b0;
		end
	end

	// pattern condition held from one polling cycle to the next
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pattern_active_q <= 1'b0;
		end else if (poll_done_in) begin
			pattern_active_q <= pattern_cond; // RL15
		end else if (!pattern_detect_enable) begin
			pattern_active_q <= 1'b0; // RL10
		end
	end

	// pattern status flag, cleared only after the condition has gone
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pattern_event_flag_q <= 1'b0;
		end else if (poll_done_in && pattern_cond) begin
			pattern_event_flag_q <= 1'b1; // RL14
		end else if (main_irq_clear_in && !pattern_active_q) begin
			pattern_event_flag_q <= 1'b0; // RL16
		end
	end

	// register write decode
	always_comb begin
		wr_repeat_rate_enable = reg_req_in.write && reg_req_in.addr == ADDR_REPEAT_RATE_ENABLE;
		wr_multi_touch_config = reg_req_in.write && reg_req_in.addr == ADDR_MULTI_TOUCH_CONFIG;
		wr_touch_pattern_config = reg_req_in.write && reg_req_in.addr == ADDR_TOUCH_PATTERN_CONFIG;
		wr_touch_pattern = reg_req_in.write && reg_req_in.addr == ADDR_TOUCH_PATTERN;
	end

	// repeat rate enable register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			repeat_rate_enable_q <= RST_REPEAT_RATE_ENABLE; // RL1
		end else if (wr_repeat_rate_enable) begin
			repeat_rate_enable_q <= reg_req_in.wdata; // RL1
		end
	end

	// multiple touch configuration register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			multi_touch_config_q <= RST_MULTI_TOUCH_CONFIG; // RL4
		end else if (wr_multi_touch_config) begin
			multi_touch_config_q <= reg_req_in.wdata & MASK_MULTI_TOUCH_CONFIG; // RL19
		end
	end

	// pattern configuration register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			touch_pattern_config_q <= RST_TOUCH_PATTERN_CONFIG; // RL10
		end else if (wr_touch_pattern_config) begin
			touch_pattern_config_q <= reg_req_in.wdata & MASK_TOUCH_PATTERN_CONFIG; // RL19
		end
	end

	// pattern register
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			touch_pattern_q <= RST_TOUCH_PATTERN; // RL17
		end else if (wr_touch_pattern) begin
			touch_pattern_q <= reg_req_in.wdata; // RL17
		end
	end

	// read answer strobe, one cycle after the read request
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= reg_req_in.read;
		end
	end

	// read data, held until the next read; unmapped offsets read zero
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			rdata_q <= 8'h00;
		end else if (reg_req_in.read) begin
			unique case (reg_req_in.addr)
				ADDR_REPEAT_RATE_ENABLE: rdata_q <= repeat_rate_enable_q;
				ADDR_MULTI_TOUCH_CONFIG: rdata_q <= multi_touch_config_q;
				ADDR_TOUCH_PATTERN_CONFIG: rdata_q <= touch_pattern_config_q;
				ADDR_TOUCH_PATTERN: rdata_q <= touch_pattern_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// outputs
	assign reg_rdata_out = rdata_q;
	assign reg_rvalid_out = rvalid_q;
	assign touch_status_out = accepted_q;
	assign touch_irq_out = touch_irq_q;
	assign simul_touch_flag_out = simul_touch_flag_q;
	assign pattern_event_flag_out = pattern_event_flag_q;
	assign pattern_block_out = pattern_active_q; // RL15
	// alert pin low while the flag stands and alerts are enabled
	assign alert_n_out = ~(pattern_event_flag_q & pattern_alert_enable); // RL14

endmodule

// *** touch_host_model.sv ***
// host model: register strobes and main interrupt clear
module touch_host_model
	import touch_gate_pkg::*;
(
	// clock
	input wire logic core_clk_in,
	// register port
	output reg_req_t reg_req_out,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_rvalid_in,
	// interrupt clear
	output logic main_irq_clear_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle at time zero
	initial begin
		reg_req_out = '0;
		main_irq_clear_out = 1'b0;
	end
	// one write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		#1 reg_req_out = '{1'b1, 1'b0, a, d};
		@(posedge core_clk_in);
		#1 reg_req_out = '0;
	endtask
	// one read strobe, answer one cycle on
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
		@(posedge core_clk_in);
		#1 reg_req_out = '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk_in);
		#1 reg_req_out = '0;
		ok = reg_rvalid_in;
		d = reg_rdata_in;
	endtask
	// host writes zero to the main interrupt bit
	task automatic clr();
		@(posedge core_clk_in);
		#1 main_irq_clear_out = 1'b1;
		@(posedge core_clk_in);
		#1 main_irq_clear_out = 1'b0;
	endtask
endmodule

// *** touch_repeat_gate_chk.sv ***
// port assertions for the touch gate
module touch_repeat_gate_chk
	import touch_gate_pkg::*;
(
	// watched ports
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire reg_req_t reg_req_in,
	input wire logic reg_rvalid_out,
	input wire logic poll_done_in,
	input wire logic repeat_tick_in,
	input wire logic main_irq_clear_in,
	input wire logic [NUM_INPUTS-1:0] touch_status_out,
	input wire logic touch_irq_out,
	input wire logic simul_touch_flag_out,
	input wire logic pattern_event_flag_out,
	input wire logic pattern_block_out,
	input wire logic alert_n_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// steps of a read and of a new acceptance
	sequence rd_take_s; reg_req_in.read; endsequence
	sequence new_acc_s;
		poll_done_in ##1 ((touch_status_out & ~$past(touch_status_out)) != '0);
	endsequence
	rd_answer_a: assert property (rd_take_s |=> reg_rvalid_out)
		else $error("read not answered");
	rd_quiet_a: assert property (!reg_req_in.read |=> !reg_rvalid_out)
		else $error("stray read answer");
	new_irq_a: assert property (new_acc_s |-> touch_irq_out)
		else $error("new touch without irq");
	irq_cause_a: assert property (!poll_done_in && !repeat_tick_in |=> !touch_irq_out)
		else $error("irq without cause");
	status_hold_a: assert property (!poll_done_in |=> $stable(touch_status_out))
		else $error("status moved without poll");
	block_all_a: assert property (pattern_block_out |-> touch_status_out == '0)
		else $error("touch passed during block");
	alert_flag_a: assert property (!alert_n_out |-> pattern_event_flag_out)
		else $error("alert without flag");
	flag_hold_a: assert property (pattern_block_out |=> pattern_event_flag_out)
		else $error("flag lost while blocked");
	flag_sticky_a: assert property (pattern_event_flag_out && !main_irq_clear_in
		|=> pattern_event_flag_out)
		else $error("flag lost without clear");
	simul_sticky_a: assert property (simul_touch_flag_out && !main_irq_clear_in
		|=> simul_touch_flag_out)
		else $error("simul flag lost");
endmodule
bind touch_repeat_gate touch_repeat_gate_chk touch_repeat_gate_chk_inst (.core_clk_in,
	.reset_in, .reg_req_in, .reg_rvalid_out, .poll_done_in, .repeat_tick_in,
	.main_irq_clear_in, .touch_status_out, .touch_irq_out, .simul_touch_flag_out,
	.pattern_event_flag_out, .pattern_block_out, .alert_n_out);

// *** touch_repeat_gate_test.sv ***
// self-checking bench for the touch gate
module touch_repeat_gate_test;
	import touch_gate_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic poll_done = 1'b0;
	logic tick = 1'b0;
	poll_result_t poll = '0;
	reg_req_t req;
	thresh_ctx_t thr;
	logic [7:0] rdata, st;
	logic rvalid, clr, irq, simul, pflag, pblock, alert_n;
	logic stby = 1'b0;
	logic [6:0] sthr = 7'h10;
	logic rel_en = 1'b1;
	int errors = 0;
	int total_checks = 0;
	// active thresholds of 64, standby state and threshold driven by scenarios
	assign thr = {stby, sthr, {8{7'h40}}};
	always #2 core_clk_in = ~core_clk_in;
	// design and host
	touch_repeat_gate touch_repeat_gate_inst (.core_clk_in, .reset_in, .reg_req_in(req),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .poll_done_in(poll_done),
		.poll_in(poll), .thresh_in(thr), .repeat_tick_in(tick), .release_irq_enable_in(rel_en),
		.main_irq_clear_in(clr), .touch_status_out(st), .touch_irq_out(irq),
		.simul_touch_flag_out(simul), .pattern_event_flag_out(pflag),
		.pattern_block_out(pblock), .alert_n_out(alert_n));
	touch_host_model touch_host_model_inst (.core_clk_in, .reg_req_out(req),
		.reg_rdata_in(rdata), .reg_rvalid_in(rvalid), .main_irq_clear_out(clr));
	task automatic give_verdict();
		if (errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		touch_host_model_inst.wr(a, d);
	endtask
	// read with answer check
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit ok;
		touch_host_model_inst.rd(a, d, ok);
		if (!ok) begin
			errors++;
			$display("[FAIL] %0t no read answer", $time);
			give_verdict();
		end else chk(d, exp);
	endtask
	// one polling cycle, deltas of 9 on hit inputs
	task automatic do_poll(input logic [7:0] t, input logic [7:0] n, input logic [7:0] h);
		@(posedge core_clk_in);
		#1 poll_done = 1'b1;
		poll.touch = t;
		poll.noise = n;
		for (int i = 0; i < 8; i++) poll.delta[i] = h[i] ? 8'h09 : 8'h00;
		@(posedge core_clk_in);
		#1 poll_done = 1'b0;
	endtask
	task automatic pulse_tick();
		@(posedge core_clk_in);
		#1 tick = 1'b1;
		@(posedge core_clk_in);
		#1 tick = 1'b0;
	endtask
	task automatic t_regs();
		rchk(8'h28, 8'hff);
		rchk(8'h2a, 8'h80);
		rchk(8'h2b, 8'h00);
		rchk(8'h2d, 8'hff);
		rchk(8'h29, 8'h00);
		wr(8'h2a, 8'hff);
		rchk(8'h2a, 8'h8c);
		wr(8'h2b, 8'hff);
		rchk(8'h2b, 8'h8f);
		wr(8'h2b, 8'h00);
	endtask
	task automatic t_block();
		for (int c = 0; c < 4; c++) begin
			wr(8'h2a, 8'h80 | 8'(c << 2));
			do_poll(8'hff, 8'h00, 8'h00);
			chk(st, (8'h02 << c) - 8'h01);
			chk(simul, 1'b1);
			do_poll(8'h00, 8'h00, 8'h00);
			touch_host_model_inst.clr();
		end
		wr(8'h2a, 8'h80);
		do_poll(8'h06, 8'h00, 8'h00);
		chk(st, 8'h02);
		do_poll(8'h06, 8'h00, 8'h00);
		chk({st[6:0], irq}, 8'h04);
		do_poll(8'h05, 8'h00, 8'h00);
		chk(st, 8'h01);
		wr(8'h2a, 8'h00);
		touch_host_model_inst.clr();
		do_poll(8'hff, 8'h00, 8'h00);
		chk({simul, st}, 9'h0ff);
	endtask
	task automatic t_repeat();
		wr(8'h28, 8'h00);
		pulse_tick();
		chk(irq, 1'b0);
		wr(8'h28, 8'h80);
		pulse_tick();
		chk(irq, 1'b1);
		do_poll(8'h00, 8'h00, 8'h00);
		chk(irq, 1'b1);
		rel_en = 1'b0;
		do_poll(8'h01, 8'h00, 8'h00);
		chk(irq, 1'b1);
		pulse_tick();
		chk(irq, 1'b0);
		do_poll(8'h00, 8'h00, 8'h00);
		chk(irq, 1'b0);
		rel_en = 1'b1;
	endtask
	// threshold fractions of the standby and active thresholds
	task automatic t_thresh();
		touch_host_model_inst.clr();
		wr(8'h2b, 8'h88);
		stby = 1'b1;
		sthr = 7'h18;
		do_poll(8'h00, 8'h00, 8'h30);
		chk({pblock, pflag}, 2'h0);
		sthr = 7'h10;
		do_poll(8'h00, 8'h00, 8'h30);
		chk({pblock, pflag}, 2'h3);
		stby = 1'b0;
		do_poll(8'h00, 8'h00, 8'h30);
		chk(pblock, 1'b0);
		wr(8'h2b, 8'h8c);
		stby = 1'b1;
		sthr = 7'h08;
		do_poll(8'h00, 8'h00, 8'h30);
		chk(pblock, 1'b1);
		stby = 1'b0;
		do_poll(8'h00, 8'h00, 8'h30);
		chk(pblock, 1'b0);
	endtask
	task automatic t_pattern();
		wr(8'h2d, 8'h03);
		wr(8'h2b, 8'h81);
		do_poll(8'hff, 8'h00, 8'h30);
		chk({pblock, pflag, alert_n, st}, 11'h600);
		touch_host_model_inst.clr();
		chk(pflag, 1'b1);
		do_poll(8'h01, 8'h00, 8'h00);
		touch_host_model_inst.clr();
		chk({pblock, pflag, alert_n, st}, 11'h101);
		wr(8'h2b, 8'h83);
		do_poll(8'h00, 8'h00, 8'h30);
		chk(pblock, 1'b0);
		do_poll(8'h00, 8'h02, 8'h01);
		chk(pblock, 1'b1);
		wr(8'h2b, 8'h84);
		do_poll(8'h00, 8'h00, 8'h30);
		chk(pblock, 1'b0);
		touch_host_model_inst.clr();
		do_poll(8'h00, 8'hff, 8'h00);
		chk({pblock, pflag, alert_n}, 3'h7);
		wr(8'h2b, 8'h01);
		do_poll(8'h00, 8'hff, 8'h00);
		chk(pblock, 1'b0);
	endtask
	// reset, then the scenarios
	initial begin
		repeat (10) @(posedge core_clk_in);
		#1 reset_in = 1'b0;
		t_regs();
		t_block();
		t_repeat();
		t_pattern();
		t_thresh();
		give_verdict();
	end
endmodule
